// ### pkg/rsq_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  row sequencer; assumes a 32-bit avalon-mm slave with byte addresses.
*/
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH
// register byte offsets
`define RSQ_REG_CTRL 5'h00
`define RSQ_REG_STATUS 5'h04
`define RSQ_REG_ROWPOS 5'h08
`define RSQ_REG_COLPOS 5'h0C
`define RSQ_REG_FRAMES 5'h10
// ctrl fields and reset value
`define RSQ_CTRL_ENABLE 0
`define RSQ_CTRL_EXT_DARK 1
`define RSQ_CTRL_RESET 2'h1
// status fields
`define RSQ_ST_SUB 0
`define RSQ_ST_SHORT_CLK 1
`define RSQ_ST_COL_EOS 2
// scan geometry
`define RSQ_ROW_FIRST 11'h002
`define RSQ_COL_FIRST 11'h003
`define RSQ_COL_DARK_AT 11'h002
`define RSQ_ROW_EOS_FULL 11'h408
`define RSQ_ROW_EOS_SUB 11'h104
`define RSQ_COL_EOS_FULL 11'h509
`define RSQ_COL_EOS_SUB 11'h144
`define RSQ_SUB_SHIFT 2
// least row clock high time
`define RSQ_CLK_MHZ 250
`define RSQ_TC_NS 25
`define RSQ_TC_CYC ((`RSQ_TC_NS * `RSQ_CLK_MHZ + 999) / 1000)
`endif

// ### pkg/rsq_pkg.sv
/*
  types shared by the row sequencer modules; no assumptions.
*/
package rsq_pkg;
    typedef logic [10:0] rsq_idx_t;
    // pointer states, gray along idle-sync-run-done
    typedef enum logic [1:0] {
        PS_IDLE = 2'h0,
        PS_SYNC = 2'h1,
        PS_RUN = 2'h3,
        PS_DONE = 2'h2
    } rsq_ptr_e;
endpackage

// ### verilog/rsq_pin_sync.sv
/*
  three-flop synchroniser for a group of pins; a change counts once the
  second and third stages agree. assumes inputs asynchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rsq_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_pins,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_r, s2_r, s3_r;
    // shift chain, first stage only feeds the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= i_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // accept bits where stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_level <= RST_VAL;
        end else begin
            o_level <= (s2_r & s3_r) | (o_level & (s2_r ^ s3_r));
        end
    end
endmodule
`default_nettype wire

// ### verilog/rsq_scan_ptr.sv
/*
  one scan pointer shift register: start pulse, falling-edge stepping,
  full and subsample progression, dark slot and end-of-scan flag.
  assumes i_start and i_fall are synchronised one-cycle-clean levels/pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_scan_ptr #(
    parameter logic [10:0] FIRST = `RSQ_ROW_FIRST,
    parameter logic [10:0] DARK_AT = 11'h000,
    parameter logic [10:0] EOS_FULL = `RSQ_ROW_EOS_FULL,
    parameter logic [10:0] EOS_SUB = `RSQ_ROW_EOS_SUB
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic i_start,
    input wire logic i_fall,
    input wire logic i_sub,
    output rsq_pkg::rsq_idx_t o_idx,
    output logic o_dark,
    output logic o_done_n,
    output rsq_pkg::rsq_ptr_e o_state
);
    import rsq_pkg::*;
    rsq_idx_t k_r;
    rsq_idx_t end_of_scan;
    logic sub_r;
    rsq_ptr_e st_r;

    // position of the k-th step, stride one or four
    function automatic rsq_idx_t idx_of(rsq_idx_t k, logic sub);
        rsq_idx_t d;
        d = k - FIRST;
        idx_of = (sub ? (d << `RSQ_SUB_SHIFT) : d) + 11'h001;
    endfunction

    assign end_of_scan = sub_r ? EOS_SUB : EOS_FULL;
    assign o_state = st_r;

    // step counter, mode latched at start
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            k_r <= '0;
            sub_r <= 1'b0;
            st_r <= PS_IDLE;
        end else if (i_start) begin
            k_r <= '0;
            sub_r <= i_sub;
            st_r <= PS_SYNC;
        end else if (i_fall && i_en) begin
            unique case (st_r)
                PS_IDLE: begin
                end
                PS_SYNC: begin
                    k_r <= 11'h001;
                    st_r <= PS_RUN;
                end
                PS_RUN: begin
                    k_r <= k_r + 11'h001;
                    if (k_r + 11'h001 == end_of_scan) begin
                        st_r <= PS_DONE;
                    end
                end
                PS_DONE: begin
                    st_r <= PS_IDLE;
                end
            endcase
        end
    end

    // registered pointer outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_idx <= '0;
            o_dark <= 1'b0;
            o_done_n <= 1'b1;
        end else begin
            o_idx <= (st_r == PS_RUN && k_r >= FIRST) ? idx_of(k_r, sub_r) : '0;
            o_dark <= (DARK_AT != 11'h000) && st_r == PS_RUN && k_r == DARK_AT;
            o_done_n <= (st_r != PS_DONE);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_sync_none;
        i_start |-> ##2 (o_idx == '0) && !o_dark;
    endproperty
    a_sync_none: assert property (p_sync_none) else $error("pointer selects a row at sync");

    property p_first_real;
        (st_r == PS_RUN && k_r == FIRST - 11'h001 && i_fall && i_en && !i_start)
            |-> ##2 (o_idx == 11'h001);
    endproperty
    a_first_real: assert property (p_first_real) else $error("first real position not one");

    property p_done_at_eos;
        (st_r == PS_RUN && k_r + 11'h001 == end_of_scan && i_fall && i_en && !i_start) |-> ##2 !o_done_n;
    endproperty
    a_done_at_eos: assert property (p_done_at_eos) else $error("end of scan missing");

    property p_done_ends;
        (st_r == PS_DONE && i_fall && i_en && !i_start) |-> ##2 o_done_n;
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("end of scan longer than one period");

    c_done: cover property (!o_done_n && sub_r);
endmodule
`default_nettype wire

// ### verilog/rsq_sequencer.sv
/*
  row sequencer top: synchronises the controller pins, runs the two row
  pointers and the column pointer, models bus dark/reference, column
  sample-hold, pixel and shutter reset targets and amplifier calibration,
  and exposes control/status over an avalon-mm slave with waitrequest.
  assumes one 250 MHz clock and an external controller driving all pins.
*/
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_sequencer (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic [4:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_READOUT_ROW_CLOCK,
    input wire logic I_RESET_ROW_CLOCK,
    input wire logic I_COLUMN_CLOCK,
    input wire logic I_READOUT_ROW_START_N,
    input wire logic I_RESET_ROW_START_N,
    input wire logic I_COLUMN_START_N,
    input wire logic I_OFFSET_NULL_PULSE,
    input wire logic I_COLUMN_SAMPLE_HOLD,
    input wire logic I_SUBSAMPLE,
    input wire logic I_REG_SELECT,
    input wire logic I_PIXEL_RESET,
    input wire logic I_CAL_SLOW,
    input wire logic I_CAL_FAST,
    input wire logic [3:0] I_AMP_OFFSET_WORD,
    input wire logic [3:0] I_AMP_GAIN_WORD,
    output rsq_pkg::rsq_idx_t O_READ_ROW,
    output rsq_pkg::rsq_idx_t O_SHUTTER_ROW,
    output rsq_pkg::rsq_idx_t O_COLUMN,
    output rsq_pkg::rsq_idx_t O_FROZEN_ROW,
    output logic O_READOUT_ROW_SCAN_DONE_N,
    output logic O_RESET_ROW_SCAN_DONE_N,
    output logic O_COLUMN_SCAN_DONE_N,
    output logic O_BUS_DARK,
    output logic O_BUS_INTERNAL_REF,
    output logic O_AMP_HOLD,
    output logic O_PIXEL_RESET_ACTIVE,
    output rsq_pkg::rsq_idx_t O_PIXEL_RESET_ROW,
    output logic O_CAL_SLOW_STB,
    output logic O_CAL_FAST_ACTIVE,
    output logic O_AMP_DARK_EXTERNAL
);
    import rsq_pkg::*;
    localparam int NP = 13;
    localparam logic [NP-1:0] PIN_IDLE = 13'h0038;
    localparam logic [3:0] TC_CYC = 4'(`RSQ_TC_CYC);

    logic rst_meta_r, rst_n;
    logic [NP-1:0] pin_s, pin_d_r;
    logic rclk_s, lclk_s, xclk_s, rstart_s, lstart_s, xstart_s;
    logic sin_s, shy_s, sub_s, sel_s, prst_s, cals_s, calf_s;
    logic rfall, lfall, xfall;
    logic [1:0] ctrl_r;
    logic short_clk_r, col_eos_r, dark_tail_r;
    logic [3:0] hi_cnt_r [2];
    logic [7:0] amp_words_r;
    logic [15:0] frames_r;
    logic req, ack_r, wr_hit;
    rsq_idx_t row_r, row_l, col_x;
    logic done_r_n, done_l_n, done_x_n, col_dark;
    rsq_ptr_e st_r, st_l, st_x;

    // reset release through two flops
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // controller pins into the clock domain
    rsq_pin_sync #(.W(NP), .RST_VAL(PIN_IDLE)) u_sync (
        .i_clk(I_MCLK),
        .i_rst_n(rst_n),
        .i_pins({I_CAL_FAST, I_CAL_SLOW, I_PIXEL_RESET, I_REG_SELECT, I_SUBSAMPLE,
                 I_COLUMN_SAMPLE_HOLD, I_OFFSET_NULL_PULSE, I_COLUMN_START_N,
                 I_RESET_ROW_START_N, I_READOUT_ROW_START_N, I_COLUMN_CLOCK,
                 I_RESET_ROW_CLOCK, I_READOUT_ROW_CLOCK}),
        .o_level(pin_s)
    );
    assign {calf_s, cals_s, prst_s, sel_s, sub_s, shy_s, sin_s} = pin_s[12:6];
    assign {xclk_s, lclk_s, rclk_s} = pin_s[2:0];
    // starts are only honoured while their clock is high
    assign rstart_s = !pin_s[3] && rclk_s;
    assign lstart_s = !pin_s[4] && lclk_s;
    assign xstart_s = !pin_s[5] && xclk_s;

    // previous levels for edge detection
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_d_r <= PIN_IDLE;
        end else begin
            pin_d_r <= pin_s;
        end
    end
    assign rfall = pin_d_r[0] && !rclk_s;
    assign lfall = pin_d_r[1] && !lclk_s;
    assign xfall = pin_d_r[2] && !xclk_s;

    // readout row register
    rsq_scan_ptr #(.FIRST(`RSQ_ROW_FIRST), .DARK_AT(11'h000),
                   .EOS_FULL(`RSQ_ROW_EOS_FULL), .EOS_SUB(`RSQ_ROW_EOS_SUB)) u_row_r (
        .i_clk(I_MCLK),
        .i_rst_n(rst_n),
        .i_en(ctrl_r[`RSQ_CTRL_ENABLE]),
        .i_start(rstart_s),
        .i_fall(rfall),
        .i_sub(sub_s),
        .o_idx(row_r),
        .o_dark(),
        .o_done_n(done_r_n),
        .o_state(st_r)
    );
    // shutter reset row register
    rsq_scan_ptr #(.FIRST(`RSQ_ROW_FIRST), .DARK_AT(11'h000),
                   .EOS_FULL(`RSQ_ROW_EOS_FULL), .EOS_SUB(`RSQ_ROW_EOS_SUB)) u_row_l (
        .i_clk(I_MCLK),
        .i_rst_n(rst_n),
        .i_en(ctrl_r[`RSQ_CTRL_ENABLE]),
        .i_start(lstart_s),
        .i_fall(lfall),
        .i_sub(sub_s),
        .o_idx(row_l),
        .o_dark(),
        .o_done_n(done_l_n),
        .o_state(st_l)
    );
    // column register: dark at second fall, first real position at third
    rsq_scan_ptr #(.FIRST(`RSQ_COL_FIRST), .DARK_AT(`RSQ_COL_DARK_AT),
                   .EOS_FULL(`RSQ_COL_EOS_FULL), .EOS_SUB(`RSQ_COL_EOS_SUB)) u_col (
        .i_clk(I_MCLK),
        .i_rst_n(rst_n),
        .i_en(ctrl_r[`RSQ_CTRL_ENABLE]),
        .i_start(xstart_s),
        .i_fall(xfall),
        .i_sub(sub_s),
        .o_idx(col_x),
        .o_dark(col_dark),
        .o_done_n(done_x_n),
        .o_state(st_x)
    );
    assign O_READ_ROW = row_r;
    assign O_SHUTTER_ROW = row_l;
    assign O_COLUMN = col_x;
    assign O_READOUT_ROW_SCAN_DONE_N = done_r_n;
    assign O_RESET_ROW_SCAN_DONE_N = done_l_n;
    assign O_COLUMN_SCAN_DONE_N = done_x_n;

    // dark after column end, held until null or a column restart; a restart never sets it
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            dark_tail_r <= 1'b0;
        end else if (sin_s || xstart_s) begin
            dark_tail_r <= 1'b0;
        end else if (st_x == PS_DONE) begin
            dark_tail_r <= 1'b1;
        end
    end

    // readout bus source and amplifier state
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_BUS_DARK <= 1'b0;
            O_BUS_INTERNAL_REF <= 1'b0;
            O_AMP_HOLD <= 1'b0;
            O_CAL_SLOW_STB <= 1'b0;
            O_CAL_FAST_ACTIVE <= 1'b0;
            O_AMP_DARK_EXTERNAL <= 1'b0;
        end else begin
            O_BUS_DARK <= !sin_s && (col_dark || dark_tail_r);
            O_BUS_INTERNAL_REF <= sin_s;
            O_AMP_HOLD <= shy_s;
            O_CAL_SLOW_STB <= cals_s && !pin_d_r[11];
            O_CAL_FAST_ACTIVE <= calf_s;
            O_AMP_DARK_EXTERNAL <= ctrl_r[`RSQ_CTRL_EXT_DARK];
        end
    end

    // column amplifiers freeze the row on sample-hold rise
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_FROZEN_ROW <= '0;
        end else if (shy_s && !pin_d_r[7]) begin
            O_FROZEN_ROW <= row_r;
        end
    end

    // pixel reset target: select high picks the shutter row
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PIXEL_RESET_ACTIVE <= 1'b0;
            O_PIXEL_RESET_ROW <= '0;
        end else begin
            O_PIXEL_RESET_ACTIVE <= prst_s;
            O_PIXEL_RESET_ROW <= sel_s ? row_l : row_r;
        end
    end

    // row clock high-time check, flags a too short high phase
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_r[0] <= '0;
            hi_cnt_r[1] <= '0;
        end else begin
            hi_cnt_r[0] <= !rclk_s ? 4'h0 : (hi_cnt_r[0] == 4'hF ? 4'hF : hi_cnt_r[0] + 4'h1);
            hi_cnt_r[1] <= !lclk_s ? 4'h0 : (hi_cnt_r[1] == 4'hF ? 4'hF : hi_cnt_r[1] + 4'h1);
        end
    end

    // sticky status; a new event wins over a clearing write
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            short_clk_r <= 1'b0;
            col_eos_r <= 1'b0;
        end else begin
            if ((rfall && hi_cnt_r[0] < TC_CYC) || (lfall && hi_cnt_r[1] < TC_CYC)) begin
                short_clk_r <= 1'b1;
            end else if (wr_hit && I_AVS_ADDRESS == `RSQ_REG_STATUS && I_AVS_WRITEDATA[`RSQ_ST_SHORT_CLK]) begin
                short_clk_r <= 1'b0;
            end
            if (st_x == PS_DONE) begin
                col_eos_r <= 1'b1;
            end else if (wr_hit && I_AVS_ADDRESS == `RSQ_REG_STATUS && I_AVS_WRITEDATA[`RSQ_ST_COL_EOS]) begin
                col_eos_r <= 1'b0;
            end
        end
    end

    // frame count and amplifier words latched at readout start
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            frames_r <= '0;
            amp_words_r <= '0;
        end else if (rstart_s && !(pin_d_r[0] && !pin_d_r[3])) begin
            frames_r <= frames_r + 16'h0001;
            amp_words_r <= {I_AMP_GAIN_WORD, I_AMP_OFFSET_WORD};
        end
    end

    // avalon slave: one wait cycle, answer on the second edge
    assign req = (I_AVS_READ || I_AVS_WRITE);
    assign O_AVS_WAITREQUEST = req && !ack_r;
    assign wr_hit = I_AVS_WRITE && ack_r && I_AVS_BYTEENABLE[0];
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            O_AVS_READDATA <= '0;
        end else begin
            ack_r <= req && !ack_r;
            if (I_AVS_READ && !ack_r) begin
                unique case (I_AVS_ADDRESS)
                    `RSQ_REG_CTRL: O_AVS_READDATA <= {30'h0, ctrl_r};
                    `RSQ_REG_STATUS: O_AVS_READDATA <= {16'h0, amp_words_r, 2'h0, done_x_n, done_l_n,
                                                        done_r_n, col_eos_r, short_clk_r, sub_s};
                    `RSQ_REG_ROWPOS: O_AVS_READDATA <= {5'h0, row_l, 5'h0, row_r};
                    `RSQ_REG_COLPOS: O_AVS_READDATA <= {5'h0, O_FROZEN_ROW, 5'h0, col_x};
                    `RSQ_REG_FRAMES: O_AVS_READDATA <= {16'h0, frames_r};
                    default: O_AVS_READDATA <= '0;
                endcase
            end
        end
    end

    // control register write
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `RSQ_CTRL_RESET;
        end else if (wr_hit && I_AVS_ADDRESS == `RSQ_REG_CTRL) begin
            ctrl_r <= I_AVS_WRITEDATA[1:0];
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!rst_n);

    property p_null_forces_ref;
        sin_s |=> O_BUS_INTERNAL_REF && !O_BUS_DARK;
    endproperty
    a_null_forces_ref: assert property (p_null_forces_ref) else $error("reference not forced by null");

    property p_tail_after_eos;
        (st_x == PS_DONE && !sin_s && !xstart_s) |=> dark_tail_r ##1 (O_BUS_DARK || sin_s || $past(sin_s));
    endproperty
    a_tail_after_eos: assert property (p_tail_after_eos) else $error("no dark after column end");

    property p_restart_no_dark;
        (xstart_s && st_x != PS_DONE) |=> !dark_tail_r;
    endproperty
    a_restart_no_dark: assert property (p_restart_no_dark) else $error("dark after early restart");

    property p_freeze;
        $rose(shy_s) |=> (O_FROZEN_ROW == $past(row_r)) ##1 O_AMP_HOLD;
    endproperty
    a_freeze: assert property (p_freeze) else $error("row not frozen on sample-hold");

    property p_slow_cal;
        $rose(cals_s) |=> O_CAL_SLOW_STB ##1 !O_CAL_SLOW_STB;
    endproperty
    a_slow_cal: assert property (p_slow_cal) else $error("slow calibration strobe wrong");

    c_shutter_reset: cover property (O_PIXEL_RESET_ACTIVE && sel_s);
    c_col_eos: cover property (!done_x_n ##[1:20] O_BUS_DARK);
    c_bus_read: cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
endmodule
`default_nettype wire

// ### test/rsq_ctl_model.sv
/*
  timing-generator model: start pulses, pointer clocks, pixel reset,
  sample-hold, calibration pulses and the offset-null pulse.
  assumes a free-running bench clock; clocks idle high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module rsq_ctl_model #(
    parameter int H = 10,
    parameter int TN = 750
) (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_sub,
    input wire logic [10:0] i_falls_row,
    input wire logic [10:0] i_falls_col,
    output logic o_row_clk,
    output logic o_col_clk,
    output logic o_start_n,
    output logic o_sub,
    output logic o_null,
    output logic o_shy,
    output logic o_prst,
    output logic o_cals,
    output logic o_calf,
    output logic o_busy
);
    int n;
    // one frame per go, paced by counters only
    initial begin
        {o_row_clk, o_col_clk, o_start_n, o_sub, o_null, o_busy} = 6'b111000;
        {o_shy, o_prst, o_cals, o_calf} = 4'h0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_busy <= 1'b1;
                o_sub <= i_sub;
                repeat (H) @(posedge i_clk);
                o_start_n <= 1'b0;
                repeat (H) @(posedge i_clk);
                o_start_n <= 1'b1;
                for (n = 0; n < i_falls_row || n < i_falls_col; n++) begin
                    // pixel reset, then sample-hold, once three rows have passed
                    if (n == 3) begin
                        o_prst <= 1'b1;
                        repeat (H) @(posedge i_clk);
                        o_prst <= 1'b0;
                        repeat (H) @(posedge i_clk);
                        o_shy <= 1'b1;
                        repeat (5 * H) @(posedge i_clk);
                        o_shy <= 1'b0;
                    end
                    repeat (H) @(posedge i_clk);
                    o_row_clk <= (n >= i_falls_row);
                    o_col_clk <= (n >= i_falls_col);
                    repeat (H) @(posedge i_clk);
                    {o_row_clk, o_col_clk} <= 2'b11;
                end
                repeat (H) @(posedge i_clk);
                {o_cals, o_calf} <= 2'b11;
                repeat (H) @(posedge i_clk);
                {o_cals, o_calf} <= 2'b00;
                repeat (H) @(posedge i_clk);
                o_null <= 1'b1;
                repeat (TN) @(posedge i_clk);
                o_null <= 1'b0;
                repeat (H) @(posedge i_clk);
                o_busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/rsq_sequencer_tb.sv
/*
  bench for the row sequencer: the pin model runs a full and a subsampled
  frame; queues hold expected pointer values and register words.
*/
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer_tb;
    import rsq_pkg::*;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, go = 0, sub = 0;
    logic [4:0] adr = '0;
    logic [3:0] be = 4'hF, gw = '0, ow = '0;
    logic [31:0] wd = '0, rdat, lf = 32'h51F0C292;
    logic [10:0] nr = '0, nc = '0, er = '0, ec = '0;
    logic wait_r, rck, cck, st_n, psub, nul, busy, rdn, sdn, cdn, dark, iref;
    logic prd = 1, pcd = 1, pdk = 0, pnl = 0;
    logic column_sample_hold, prst, cals, calf, hold, pra, stb, fa, ext, pshy = 0, ppr = 0, pcf = 0;
    rsq_idx_t fr, prr, pfr = '0;
    int dk = 0, ns = 0;
    rsq_idx_t row, srow, col, prow = '0, pcol = '0;
    int rf = 0, cf = 0, bad_count = 0, compares = 0;
    logic [31:0] qr[$], qc[$], qb[$];
    always #2 clk = ~clk;
    rsq_ctl_model u_rsq_ctl_model (.i_clk(clk), .i_go(go), .i_sub(sub), .i_falls_row(nr), .i_falls_col(nc),
        .o_row_clk(rck), .o_col_clk(cck), .o_start_n(st_n), .o_sub(psub), .o_null(nul), .o_shy(column_sample_hold),
        .o_prst(prst), .o_cals(cals), .o_calf(calf), .o_busy(busy));
    rsq_sequencer u_rsq_sequencer (.I_MCLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wait_r), .I_READOUT_ROW_CLOCK(rck), .I_RESET_ROW_CLOCK(rck), .I_COLUMN_CLOCK(cck),
        .I_READOUT_ROW_START_N(st_n), .I_RESET_ROW_START_N(st_n), .I_COLUMN_START_N(st_n),
        .I_OFFSET_NULL_PULSE(nul), .I_COLUMN_SAMPLE_HOLD(column_sample_hold), .I_SUBSAMPLE(psub),
        .I_REG_SELECT(1'b0), // shutter unused: select low, no second reset
        .I_PIXEL_RESET(prst), .I_CAL_SLOW(cals), .I_CAL_FAST(calf), .I_AMP_OFFSET_WORD(ow),
        .I_AMP_GAIN_WORD(gw), .O_READ_ROW(row), .O_SHUTTER_ROW(srow), .O_COLUMN(col), .O_FROZEN_ROW(fr),
        .O_READOUT_ROW_SCAN_DONE_N(rdn), .O_RESET_ROW_SCAN_DONE_N(sdn), .O_COLUMN_SCAN_DONE_N(cdn),
        .O_BUS_DARK(dark), .O_BUS_INTERNAL_REF(iref), .O_AMP_HOLD(hold), .O_PIXEL_RESET_ACTIVE(pra),
        .O_PIXEL_RESET_ROW(prr), .O_CAL_SLOW_STB(stb), .O_CAL_FAST_ACTIVE(fa), .O_AMP_DARK_EXTERNAL(ext));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one bus cycle; a read notes its expected word
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        if (!w) qb.push_back(d);
        @(posedge clk);
        while (wait_r !== 1'b0) @(posedge clk);
        rd <= 0;
        wr <= 0;
    endtask
    // one frame: note expected pointers, run the model, read status
    task automatic frame(input logic s);
        int n;
        sub = s;
        er = s ? 11'd260 : 11'd1032;
        ec = s ? 11'd324 : 11'd1289;
        lf = lfsr(lf);
        gw <= lf[3:0];
        ow <= lf[7:4];
        for (n = 2; n < er; n++) qr.push_back(1 + (n - 2) * (s ? 4 : 1));
        for (n = 3; n < ec; n++) qc.push_back(1 + (n - 3) * (s ? 4 : 1));
        nr = er + 1;
        nc = ec + 1;
        @(posedge clk);
        go <= 1;
        @(posedge clk);
        go <= 0;
        wait (busy);
        wait (!busy);
        repeat (10) @(posedge clk);
        chk(dark, 0);
        chk(qr.size() + qc.size(), 0);
        chk(ns, s + 1);
        bus(0, 5'h04, {16'h0, gw, ow, 2'b0, 3'b111, 2'b10, s});
    endtask
    // pin counters: falls since the last start pulse
    always @(negedge st_n) begin
        rf = 0;
        cf = 0;
        dk = 0;
    end
    always @(negedge rck) rf++;
    always @(negedge cck) cf++;
    // watcher: each new result takes the oldest note off its queue
    always @(posedge clk) if (rst_n) begin
        if (row !== prow && row !== 0 && rdn === 1'b1) begin
            chk(row, qr.pop_front());
            chk(srow, row);
        end
        if (col !== pcol && col !== 0 && cdn === 1'b1) chk(col, qc.pop_front());
        if (rd && wait_r === 1'b0) chk(rdat, qb.pop_front());
        if (rdn !== prd) chk(rf, prd ? er : er + 1);
        if (rdn !== prd) chk(sdn, rdn);
        if (cdn !== pcd) chk(cf, pcd ? ec : ec + 1);
        if (dark === 1'b1 && !pdk) begin
            chk(cf, dk ? ec : 2);
            dk = 1;
        end
        if (nul && !pnl) chk(dark, 1);
        if (!nul && pnl) chk(iref, 1);
        if (stb === 1'b1) begin
            ns++;
            chk(dark, 1);
        end
        if (!calf && pcf) chk(fa, 1);
        if (!column_sample_hold && pshy) chk(hold, 1);
        if (fr !== pfr) chk(fr, sub ? 5 : 2);
        if (!prst && ppr) chk(pra, 1);
        if (!prst && ppr) chk(prr, sub ? 5 : 2);
        {prow, pcol, prd, pcd, pdk, pnl} = {row, col, rdn, cdn, dark, nul};
        {pfr, pshy, ppr, pcf} = {fr, column_sample_hold, prst, calf};
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        bus(0, 5'h14, 0); // unmapped reads zero
        be <= 4'h0;
        bus(1, 5'h00, 0); // refused without byte 0
        be <= 4'hF;
        bus(0, 5'h00, 1); // stepping still enabled
        bus(1, 5'h00, 32'h3); // enable and external dark select
        bus(0, 5'h00, 3);
        chk(ext, 1);
        frame(0);
        frame(1);
        bus(0, 5'h10, 2);
        stop_test;
    end
    // watchdog
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule
`default_nettype wire
